// ---- hfp_defs.vh ----
// Constants for the host FIFO port access block: map, field positions, defaults.
`ifndef HFP_DEFS_VH
`define HFP_DEFS_VH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define HFP_FIFO_AW 4
`define HFP_DATA_W 32
`define HFP_HOST_W 16

// ----------------------------------------------------------------------------
// Byte offsets (host_addr[7:0]); data ports are windows selected by addr[7:6]
// ----------------------------------------------------------------------------
`define HFP_WIN_RXD 2'h0
`define HFP_WIN_TXD 2'h1
`define HFP_OFF_RXS_POP 8'h80
`define HFP_OFF_RXS_PEEK 8'h84
`define HFP_OFF_TXS_POP 8'h88
`define HFP_OFF_TXS_PEEK 8'h8C
`define HFP_OFF_CFG 8'h90
`define HFP_OFF_STS 8'h94
`define HFP_OFF_EVT 8'h98

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HFP_CFG_RXD_LSB 0
`define HFP_CFG_TXD_LSB 8
`define HFP_CFG_RXS_LSB 16
`define HFP_CFG_KEEP_BIT 29
`define HFP_CFG_SRST_BIT 31
`define HFP_STS_RXD_LSB 0
`define HFP_STS_TXD_LSB 8
`define HFP_STS_RXS_LSB 16
`define HFP_STS_TXS_LSB 24
`define HFP_EVT_RXO_BIT 0
`define HFP_EVT_TXO_BIT 1
`define HFP_EVT_UDR_BIT 2
`define HFP_EVT_LNK_BIT 3
`define HFP_EVT_ERR_BIT 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HFP_KEEP_DEF 1'b0
`define HFP_LNK_DEF 1'b1
`define HFP_ERR_DEF 1'b0
`define HFP_ZERO32 32'h00000000

`endif

// ---- hfp_fifo.v ----
// Synchronous FIFO with a programmable fill limit and registered flags.
`timescale 1ns/10ps
`include "hfp_defs.vh"

module hfp_fifo #(
  parameter DW = 32,
  parameter AW = 4
) (
  input wire clk,                 // System clock.
  input wire clr,                 // Synchronous clear, active high.
  input wire [AW:0] limit,        // Usable depth; zero or above depth means full depth.
  input wire push,                // Write strobe.
  input wire [DW-1:0] push_data,  // Write word.
  input wire pop,                 // Remove head strobe.
  output wire [DW-1:0] head,      // Oldest word.
  output reg [AW:0] count_q,      // Fill level.
  output reg full_q,              // Level has reached the limit.
  output reg empty_q              // No word held.
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam [AW:0] ZERO = {(AW+1){1'b0}};

  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] count_d;
  wire do_push = push & ~full_q;
  wire do_pop = pop & ~empty_q;
  wire [AW:0] eff = ((limit == ZERO) || (limit > DEPTH)) ? DEPTH : limit;

  assign head = mem[rp_q];

  always @*
  begin
    count_d = count_q;
    if (do_push & ~do_pop)
      count_d = count_q + 1'b1;
    else if (do_pop & ~do_push)
      count_d = count_q - 1'b1;
  end

  always @(posedge clk)
  begin
    if (do_push)
      mem[wp_q] <= push_data;
  end

  // Full is refreshed every cycle so a new limit takes effect at once.
  always @(posedge clk)
  begin
    if (clr)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      count_q <= ZERO;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      if (do_push)
        wp_q <= wp_q + 1'b1;
      if (do_pop)
        rp_q <= rp_q + 1'b1;
      count_q <= count_d;
      full_q <= (count_d >= eff);
      empty_q <= (count_d == ZERO);
    end
  end

endmodule

// ---- hfp_mac_model.sv ----
// Model of the receive and transmit logic that feeds and drains the FIFOs.
`timescale 1ns/10ps
module hfp_mac_model (
  input wire mclk, // System clock.
  output reg rxs_push, // Receive status strobe.
  output reg [31:0] rxs_data, // Receive status word.
  output reg rxd_push, // Receive data strobe.
  output reg [31:0] rxd_data, // Receive data word.
  output reg txs_push, // Transmit status strobe.
  output reg [31:0] txs_data, // Transmit status word.
  output reg txd_req // Transmit word request.
);
  initial
  begin
    {txs_push, rxd_push, rxs_push} = 3'h0;
    {rxs_data, rxd_data, txs_data} = {3{32'hFFFFFFFF}};
    txd_req = 1'b0;
  end

  // Lane 0 receive status, 1 receive data, 2 transmit status; all lanes carry the word in the strobe cycle, its inverse after.
  task push(input integer sel, input [31:0] d);
    begin
      {txs_push, rxd_push, rxs_push} = 3'h1 << sel;
      {rxs_data, rxd_data, txs_data} = {3{d}};
      @(negedge mclk);
      {txs_push, rxd_push, rxs_push} = 3'h0;
      {rxs_data, rxd_data, txs_data} = {3{~d}};
      @(negedge mclk);
    end
  endtask

  task pull;
    begin
      txd_req = 1'b1;
      @(negedge mclk);
      txd_req = 1'b0;
      @(negedge mclk);
    end
  endtask
endmodule

// ---- hfp_port.v ----
// Host access logic: 16-bit pairing, register attributes and four FIFO ports.
//
// How it works
// RULE1 - Host bus 16 bits, internal words 32.
// RULE2 - Two 16-bit halves form one internal access.
// RULE3 - Writes to read-only registers are ignored.
// RULE4 - Write-only locations always read back zero.
// RULE5 - Writing one clears the bit; zero ignored.
// RULE6 - Reading a clear-on-read bit clears it.
// RULE7 - Latched status holds until register read.
// RULE8 - Self-clearing bits drop after their action.
// RULE9 - Soft-reset-immune bits survive software reset.
// RULE10 - Host writes reserved bits as zero.
// RULE11 - Host never writes reserved registers.
// RULE12 - Any reset loads all defaults; software reset leaves keep_q unchanged (RULE9).
// RULE13 - Four host FIFOs: RX/TX status, data.
// RULE14 - Data and RX status sizes configurable.
// RULE15 - RX status and data read-only.
// RULE16 - RX status pop read returns, removes.
// RULE17 - RX status peek read returns, keeps.
// RULE18 - RX data read returns and removes.
// RULE19 - RX data aliased over sixteen words.
// RULE20 - TX status pop removes, peek keeps.
// RULE21 - TX data written at sixteen aliases.
// RULE22 - TX data reads return zero, no change.
`timescale 1ns/10ps
`include "hfp_defs.vh"

module hfp_port #(
  parameter AW = `HFP_FIFO_AW
) (
  input wire mclk,                // System clock, 40 MHz.
  input wire reset_n,             // System reset, synchronous, active low.
  input wire por_n,               // Power-on reset, synchronous, active low.
  input wire [7:0] host_addr,     // Byte address; bit 1 selects the upper half.
  input wire [15:0] host_wdata,   // Host write half-word.
  input wire host_rd,             // Read strobe, one cycle.
  input wire host_wr,             // Write strobe, one cycle.
  output reg [15:0] host_rdata_q, // Read half-word.
  output reg host_rvalid_q,       // Read data valid, one cycle.
  input wire rxs_push,            // Receive status word strobe.
  input wire [31:0] rxs_data,     // Receive status word.
  output wire rxs_full_q,         // Receive status FIFO at its limit.
  input wire rxd_push,            // Receive data word strobe.
  input wire [31:0] rxd_data,     // Receive data word.
  output wire rxd_full_q,         // Receive data FIFO at its limit.
  input wire txs_push,            // Transmit status word strobe.
  input wire [31:0] txs_data,     // Transmit status word.
  output wire txs_full_q,         // Transmit status FIFO full.
  input wire txd_req,             // Transmit data word request.
  output reg [31:0] txd_word_q,   // Transmit data word.
  output reg txd_word_vld_q,      // Transmit data word valid, one cycle.
  input wire link_ok,             // Link level, latched low.
  input wire phy_error            // Error level, latched high.
);

  localparam CW = AW + 1;
  localparam [AW:0] LIM_DEF = {1'b1, {AW{1'b0}}};

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [15:0] wlo_q;
  reg wlo_vld_q;
  reg [31:0] hold_q;
  reg [AW:0] rxd_lim_q;
  reg [AW:0] txd_lim_q;
  reg [AW:0] rxs_lim_q;
  reg keep_q;
  reg soft_rst_q;
  reg rxo_q;
  reg txo_q;
  reg udr_q;
  reg lnk_q;
  reg err_q;
  reg [31:0] rd32;

  wire hard_rst = ~reset_n | ~por_n;
  wire any_rst = hard_rst | soft_rst_q;
  wire [7:0] waddr = {host_addr[7:2], 2'b00};
  wire sel_rxd = (host_addr[7:6] == `HFP_WIN_RXD);
  wire sel_txd = (host_addr[7:6] == `HFP_WIN_TXD);
  wire sel_rxs_pop = (waddr == `HFP_OFF_RXS_POP);
  wire sel_rxs_peek = (waddr == `HFP_OFF_RXS_PEEK);
  wire sel_txs_pop = (waddr == `HFP_OFF_TXS_POP);
  wire sel_txs_peek = (waddr == `HFP_OFF_TXS_PEEK);
  wire sel_cfg = (waddr == `HFP_OFF_CFG);
  wire sel_sts = (waddr == `HFP_OFF_STS);
  wire sel_evt = (waddr == `HFP_OFF_EVT);

  // A lower-half read carries the internal access; a lower-half write is held until the upper-half write completes it.
  wire rd_lo = host_rd & ~host_addr[1];
  wire rd_hi = host_rd & host_addr[1];
  wire wr_hi = host_wr & host_addr[1] & wlo_vld_q;
  wire [31:0] w32 = {host_wdata, wlo_q};

  wire [31:0] rxs_head;
  wire [31:0] rxd_head;
  wire [31:0] txs_head;
  wire [31:0] txd_head;
  wire [AW:0] rxs_cnt;
  wire [AW:0] rxd_cnt;
  wire [AW:0] txs_cnt;
  wire [AW:0] txd_cnt;
  wire rxs_empty;
  wire rxd_empty;
  wire txs_empty;
  wire txd_empty;
  wire txd_full;

  wire rxd_pop = rd_lo & sel_rxd;
  wire rxs_pop = rd_lo & sel_rxs_pop;
  wire txs_pop = rd_lo & sel_txs_pop;
  wire txd_push = wr_hi & sel_txd;
  wire txd_pop = txd_req & ~txd_empty;
  wire evt_read = rd_lo & sel_evt;

  wire rxo_set = (rxd_push & rxd_full_q) | (rxs_push & rxs_full_q);
  wire txo_set = txd_push & txd_full;
  wire udr_set = (rxd_pop & rxd_empty) | (rxs_pop & rxs_empty) | (txs_pop & txs_empty);

  // --------------------------------------------------------------------------
  // FIFOs
  // --------------------------------------------------------------------------
  hfp_fifo #(.DW(`HFP_DATA_W), .AW(AW)) u_rxs (   // see RULE13
    .clk(mclk),
    .clr(any_rst),
    .limit(rxs_lim_q),
    .push(rxs_push),
    .push_data(rxs_data),
    .pop(rxs_pop),
    .head(rxs_head),
    .count_q(rxs_cnt),
    .full_q(rxs_full_q),
    .empty_q(rxs_empty)
  );

  hfp_fifo #(.DW(`HFP_DATA_W), .AW(AW)) u_rxd (
    .clk(mclk),
    .clr(any_rst),
    .limit(rxd_lim_q),
    .push(rxd_push),
    .push_data(rxd_data),
    .pop(rxd_pop),
    .head(rxd_head),
    .count_q(rxd_cnt),
    .full_q(rxd_full_q),
    .empty_q(rxd_empty)
  );

  hfp_fifo #(.DW(`HFP_DATA_W), .AW(AW)) u_txs (
    .clk(mclk),
    .clr(any_rst),
    .limit(LIM_DEF),
    .push(txs_push),
    .push_data(txs_data),
    .pop(txs_pop),
    .head(txs_head),
    .count_q(txs_cnt),
    .full_q(txs_full_q),
    .empty_q(txs_empty)
  );

  hfp_fifo #(.DW(`HFP_DATA_W), .AW(AW)) u_txd (
    .clk(mclk),
    .clr(any_rst),
    .limit(txd_lim_q),
    .push(txd_push),
    .push_data(w32),
    .pop(txd_pop),
    .head(txd_head),
    .count_q(txd_cnt),
    .full_q(txd_full),
    .empty_q(txd_empty)
  );

  // --------------------------------------------------------------------------
  // Read selection
  // --------------------------------------------------------------------------
  always @*
  begin
    rd32 = `HFP_ZERO32;
    if (sel_rxd)
      rd32 = rxd_empty ? `HFP_ZERO32 : rxd_head;   // see RULE18, RULE19
    else if (sel_txd)
      rd32 = `HFP_ZERO32;   // see RULE4, RULE22
    else if (sel_rxs_pop | sel_rxs_peek)
      rd32 = rxs_empty ? `HFP_ZERO32 : rxs_head;   // see RULE16, RULE17
    else if (sel_txs_pop | sel_txs_peek)
      rd32 = txs_empty ? `HFP_ZERO32 : txs_head;   // see RULE20
    else if (sel_cfg)
    begin
      rd32[`HFP_CFG_RXD_LSB +: CW] = rxd_lim_q;
      rd32[`HFP_CFG_TXD_LSB +: CW] = txd_lim_q;
      rd32[`HFP_CFG_RXS_LSB +: CW] = rxs_lim_q;
      rd32[`HFP_CFG_KEEP_BIT] = keep_q;
      rd32[`HFP_CFG_SRST_BIT] = soft_rst_q;
    end
    else if (sel_sts)
    begin
      rd32[`HFP_STS_RXD_LSB +: CW] = rxd_cnt;
      rd32[`HFP_STS_TXD_LSB +: CW] = txd_cnt;
      rd32[`HFP_STS_RXS_LSB +: CW] = rxs_cnt;
      rd32[`HFP_STS_TXS_LSB +: CW] = txs_cnt;
    end
    else if (sel_evt)
    begin
      rd32[`HFP_EVT_RXO_BIT] = rxo_q;
      rd32[`HFP_EVT_TXO_BIT] = txo_q;
      rd32[`HFP_EVT_UDR_BIT] = udr_q;
      rd32[`HFP_EVT_LNK_BIT] = lnk_q;
      rd32[`HFP_EVT_ERR_BIT] = err_q;
    end
  end

  // --------------------------------------------------------------------------
  // Host half-word pairing
  // --------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (any_rst)   // see RULE12
    begin
      wlo_q <= 16'h0000;
      wlo_vld_q <= 1'b0;
      hold_q <= `HFP_ZERO32;
      host_rdata_q <= 16'h0000;
      host_rvalid_q <= 1'b0;
    end
    else
    begin
      host_rvalid_q <= host_rd;
      if (rd_lo)
      begin
        hold_q <= rd32;   // see RULE1, RULE2
        host_rdata_q <= rd32[15:0];
      end
      else if (rd_hi)
        host_rdata_q <= hold_q[31:16];   // see RULE2
      if (host_wr & ~host_addr[1])
      begin
        wlo_q <= host_wdata;   // see RULE2
        wlo_vld_q <= 1'b1;
      end
      else if (host_wr)
        wlo_vld_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (hard_rst)
      keep_q <= `HFP_KEEP_DEF;   // see RULE9
    else if (wr_hi & sel_cfg)
      keep_q <= w32[`HFP_CFG_KEEP_BIT];
  end

  always @(posedge mclk)
  begin
    if (any_rst)
    begin
      rxd_lim_q <= LIM_DEF;
      txd_lim_q <= LIM_DEF;
      rxs_lim_q <= LIM_DEF;
      soft_rst_q <= 1'b0;   // see RULE8
    end
    else
    begin
      soft_rst_q <= wr_hi & sel_cfg & w32[`HFP_CFG_SRST_BIT];
      if (wr_hi & sel_cfg)
      begin
        rxd_lim_q <= w32[`HFP_CFG_RXD_LSB +: CW];   // see RULE14
        txd_lim_q <= w32[`HFP_CFG_TXD_LSB +: CW];
        rxs_lim_q <= w32[`HFP_CFG_RXS_LSB +: CW];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event register; a set in the clearing cycle wins
  // --------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (any_rst)
    begin
      rxo_q <= 1'b0;
      txo_q <= 1'b0;
      udr_q <= 1'b0;
      lnk_q <= `HFP_LNK_DEF;
      err_q <= `HFP_ERR_DEF;
    end
    else
    begin
      if (rxo_set)
        rxo_q <= 1'b1;
      else if (wr_hi & sel_evt & w32[`HFP_EVT_RXO_BIT])
        rxo_q <= 1'b0;   // see RULE5
      if (txo_set)
        txo_q <= 1'b1;
      else if (wr_hi & sel_evt & w32[`HFP_EVT_TXO_BIT])
        txo_q <= 1'b0;   // see RULE5
      if (udr_set)
        udr_q <= 1'b1;
      else if (evt_read)
        udr_q <= 1'b0;   // see RULE6
      if (evt_read)
      begin
        lnk_q <= link_ok;   // see RULE7
        err_q <= phy_error;
      end
      else
      begin
        lnk_q <= lnk_q & link_ok;
        err_q <= err_q | phy_error;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmit data drain; status and RX writes are dropped
  // --------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (any_rst)
    begin
      txd_word_q <= `HFP_ZERO32;
      txd_word_vld_q <= 1'b0;
    end
    else
    begin
      txd_word_vld_q <= txd_pop;   // see RULE21
      if (txd_pop)
        txd_word_q <= txd_head;
    end
  end

  // Writes to RX ports, status ports and the status register have no path.
  // see RULE3, RULE15

endmodule

// ---- hfp_port_properties.sv ----
// Concurrent checks on the host port and transmit handshake of the FIFO port block.
`timescale 1ns/10ps
module hfp_port_properties (
  input wire mclk, // System clock.
  input wire reset_n, // System reset.
  input wire por_n, // Power-on reset.
  input wire [7:0] host_addr, // Host address.
  input wire host_rd, // Read strobe.
  input wire host_wr, // Write strobe.
  input wire [15:0] host_rdata_q, // Read half-word.
  input wire host_rvalid_q, // Read valid.
  input wire rxd_full_q, // Receive data full.
  input wire txd_req, // Word request.
  input wire txd_word_vld_q // Word valid.
);
  // ----------------------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n || !por_n);

  sequence upper_rd;
    host_rd && host_addr[1];
  endsequence

  sequence idle3;
    (!host_rd && !host_wr)[*3];
  endsequence

  AST_READ_ANSWER: assert property (host_rd |=> host_rvalid_q) else $error("read not answered");
  AST_NO_STRAY_RVALID: assert property (host_rvalid_q |-> $past(host_rd)) else $error("stray read valid");
  AST_TXD_WIN_ZERO: assert property (
    host_rd && host_addr[7:6] == 2'h1 && !host_addr[1] |=> host_rdata_q == 16'h0000)
    else $error("transmit window read not zero");
  AST_PAIR_SNAPSHOT: assert property (upper_rd ##1 upper_rd |=> $stable(host_rdata_q))
    else $error("upper half changed without lower read");
  AST_RDATA_HOLD: assert property (idle3 |=> $stable(host_rdata_q)) else $error("read data moved while idle");
  AST_TXD_ANSWER: assert property (txd_word_vld_q |-> $past(txd_req)) else $error("word valid without request");
  AST_RESET_QUIET: assert property (disable iff (!por_n)
    !reset_n |=> !host_rvalid_q && !txd_word_vld_q && host_rdata_q == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_FULL_FALL: assert property (
    $fell(rxd_full_q) |-> $past(host_rd) || $past(host_rd, 2) || $past(host_wr)
    || $past(host_wr, 2) || $past(host_wr, 3))
    else $error("full dropped without host access");
endmodule

bind hfp_port hfp_port_properties u_props (.mclk(mclk), .reset_n(reset_n), .por_n(por_n), .host_addr(host_addr),
  .host_rd(host_rd), .host_wr(host_wr), .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
  .rxd_full_q(rxd_full_q), .txd_req(txd_req), .txd_word_vld_q(txd_word_vld_q));

// ---- hfp_port_tb_top.sv ----
// Self-checking testbench of the host FIFO port access block.
`timescale 1ns/10ps
module hfp_port_tb_top;
  reg mclk, reset_n, por_n, host_rd, host_wr, link_ok, phy_error;
  reg [7:0] host_addr;
  reg [15:0] host_wdata;
  wire [15:0] host_rdata_q;
  wire host_rvalid_q, rxs_push, rxd_push, txs_push, txd_req, rxs_full_q, rxd_full_q, txs_full_q, txd_word_vld_q;
  wire [31:0] rxs_data, rxd_data, txs_data, txd_word_q;
  logic [15:0] exp_q[$];
  logic [31:0] txw_q[$];
  logic [31:0] w[0:15];
  integer fail_count, comparisons, cycles, i, seed;

  hfp_port #(.AW(4)) DUT (.mclk(mclk), .reset_n(reset_n), .por_n(por_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr), .host_rdata_q(host_rdata_q),
    .host_rvalid_q(host_rvalid_q), .rxs_push(rxs_push), .rxs_data(rxs_data), .rxs_full_q(rxs_full_q),
    .rxd_push(rxd_push), .rxd_data(rxd_data), .rxd_full_q(rxd_full_q), .txs_push(txs_push),
    .txs_data(txs_data), .txs_full_q(txs_full_q), .txd_req(txd_req), .txd_word_q(txd_word_q),
    .txd_word_vld_q(txd_word_vld_q), .link_ok(link_ok), .phy_error(phy_error));
  hfp_mac_model mac (.mclk(mclk), .rxs_push(rxs_push), .rxs_data(rxs_data), .rxd_push(rxd_push),
    .rxd_data(rxd_data), .txs_push(txs_push), .txs_data(txs_data), .txd_req(txd_req));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------------------
  // Checking and host bus tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task rd(input [7:0] a, input [15:0] e);
    begin
      host_rd = 1'b1;
      host_wr = 1'b0;
      host_addr = a;
      exp_q.push_back(e);
      @(negedge mclk);
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      host_wr = 1'b1;
      host_rd = 1'b0;
      host_addr = a;
      host_wdata = d;
      @(negedge mclk);
    end
  endtask

  task idle(input integer n);
    begin
      host_rd = 1'b0;
      host_wr = 1'b0;
      repeat (n) @(negedge mclk);
    end
  endtask

  task rd32(input [7:0] a, input [31:0] e);
    begin
      rd(a, e[15:0]);
      rd(a | 8'h02, e[31:16]);
      idle(1);
    end
  endtask

  task wr32(input [7:0] a, input [31:0] d);
    begin
      wr(a, d[15:0]);
      wr(a | 8'h02, d[31:16]);
      idle(1);
    end
  endtask

  // Results are taken off the queues as they appear, at the settled falling edge.
  always @(negedge mclk)
  begin
    if (host_rvalid_q === 1'b1)
      check(host_rdata_q, exp_q.pop_front());
    if (txd_word_vld_q === 1'b1)
      check(txd_word_q, txw_q.pop_front());
  end

  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial
  begin
    {mclk, reset_n, por_n, host_rd, host_wr, phy_error} = 6'h00;
    link_ok = 1'b1;
    host_addr = 8'h00;
    host_wdata = 16'h0000;
    {fail_count, comparisons, cycles} = {3{32'h0}};
    seed = $urandom(42);
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    por_n = 1'b1;
    rd32(8'h90, 32'h00101010);
    rd32(8'h98, 32'h00000008);
    rd32(8'h94, 32'h00000000);
    $display("test defaults done");
    for (i = 0; i < 16; i = i + 1)
    begin
      w[0] = $urandom;
      mac.push(1, w[0]);
      rd32(8'(4 * i), w[0]);
    end
    rd(8'h02, w[0][31:16]);
    rd(8'h02, w[0][31:16]);
    idle(1);
    rd32(8'h00, 32'h00000000);
    rd32(8'h98, 32'h0000000C);
    rd32(8'h98, 32'h00000008);
    $display("test receive data aliases done");
    for (i = 0; i < 2; i = i + 1)
    begin
      w[1] = $urandom;
      w[2] = $urandom;
      mac.push(2 * i, w[1]);
      mac.push(2 * i, w[2]);
      rd32(8'(8'h84 + 8 * i), w[1]);
      rd32(8'h94, 32'h2 << (16 + 8 * i));
      rd32(8'(8'h80 + 8 * i), w[1]);
      rd32(8'(8'h84 + 8 * i), w[2]);
      rd32(8'(8'h80 + 8 * i), w[2]);
    end
    $display("test status pop and peek done");
    for (i = 0; i < 4; i = i + 1)
    begin
      w[i] = $urandom;
      wr32(8'(8'h40 + 8'h14 * i), w[i]);
    end
    wr32(8'h00, 32'h0000FFFF);
    wr32(8'h94, 32'hFFFFFFFF);
    rd32(8'h7C, 32'h00000000);
    rd32(8'h94, 32'h00000400);
    for (i = 0; i < 4; i = i + 1)
    begin
      txw_q.push_back(w[i]);
      mac.pull;
    end
    rd32(8'h94, 32'h00000000);
    $display("test transmit data done");
    wr32(8'h90, 32'h00021002);
    for (i = 0; i < 3; i = i + 1)
      mac.push(1, 32'(i));
    check(rxd_full_q, 1'b1);
    mac.push(0, 32'h0000000A);
    check(rxs_full_q, 1'b0);
    mac.push(0, 32'h0000000B);
    check(rxs_full_q, 1'b1);
    for (i = 0; i < 15; i = i + 1)
      mac.push(2, 32'(i));
    check(txs_full_q, 1'b0);
    mac.push(2, 32'h0000000F);
    check(txs_full_q, 1'b1);
    rd32(8'h98, 32'h00000009);
    wr32(8'h98, 32'h00000000);
    rd32(8'h98, 32'h00000009);
    wr32(8'h98, 32'h00000001);
    rd32(8'h98, 32'h00000008);
    rd32(8'h08, 32'h00000000);
    rd32(8'h3C, 32'h00000001);
    wr32(8'h90, 32'h00101010);
    $display("test overflow and write clear done");
    link_ok = 1'b0;
    phy_error = 1'b1;
    idle(2);
    link_ok = 1'b1;
    phy_error = 1'b0;
    idle(2);
    rd32(8'h98, 32'h00000010);
    rd32(8'h98, 32'h00000008);
    $display("test latched status done");
    mac.push(1, 32'h00001234);
    wr32(8'h90, 32'h20101010);
    wr32(8'h90, 32'hA0101010);
    idle(3);
    rd32(8'h90, 32'h20101010);
    rd32(8'h94, 32'h00000000);
    reset_n = 1'b0;
    idle(4);
    reset_n = 1'b1;
    rd32(8'h90, 32'h00101010);
    wr32(8'h90, 32'h20101010);
    por_n = 1'b0;
    idle(4);
    por_n = 1'b1;
    rd32(8'h90, 32'h00101010);
    idle(4);
    check(32'(exp_q.size() + txw_q.size()), 32'h0);
    $display("test soft and system reset done");
    end_sim;
  end
endmodule
